// ### test/bdc_debug_trace_assertions.sv
/*
  Port checker for the branch trace and debug control block.
  Assumes it is bound to bdc_debug_trace and reads that module's ports only.
*/
module bdc_debug_trace_checker (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [31:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic REG_RVALID,
  input wire logic REG_FAULT,
  input wire logic PRIV_TRACE_CAPABLE,
  input wire logic TRAP_FLAG,
  input wire logic RETIRE_VALID,
  input wire logic RETIRE_BRANCH,
  input wire logic RETIRE_TASK_SWITCH,
  input wire logic EVT_VALID,
  input wire logic EVT_READY,
  input wire logic STEP_EXC,
  input wire logic BUS_TRACE_MESSAGE_VALID,
  input wire logic STORE_WR,
  input wire logic [bdc_pkg::STORE_IDX_W-1:0] STORE_INDEX,
  input wire logic STORE_INT,
  input wire logic [bdc_pkg::NUM_GP-1:0] GP_OVF,
  input wire logic [bdc_pkg::NUM_GP-1:0] GP_PMI_EN,
  input wire logic SAMPLE_BUF_THRESH,
  input wire logic PERF_MONITOR_INTERRUPT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  logic mapped;
  assign mapped = REG_ADDR inside {bdc_pkg::DEBUG_CONTROL_ADDR, bdc_pkg::PERF_GLOBAL_STATUS_ADDR,
    bdc_pkg::GLOBAL_COUNTER_ENABLE_ADDR, bdc_pkg::PERF_OVERFLOW_RESET_ADDR};

  ////////////////////////////////////////////////////////////////////////////////
  // A branch and an event taken together leave one record pending for a cycle.
  sequence pair_taken;
    EVT_READY && RETIRE_VALID && RETIRE_BRANCH && EVT_VALID;
  endsequence
  sequence pair_drained;
    !EVT_READY ##1 EVT_READY;
  endsequence

  cap_reads_one_a: assert property (PRIV_TRACE_CAPABLE)
    else $error("capability bit low");
  read_answer_a: assert property (REG_RVALID == $past(REG_RD))
    else $error("read answer not one cycle after read");
  unmapped_fault_a: assert property (REG_RD && !mapped |=> REG_FAULT)
    else $error("no fault on unmapped read");
  status_ro_a: assert property (REG_WR && REG_ADDR == bdc_pkg::PERF_GLOBAL_STATUS_ADDR
    |=> REG_FAULT) else $error("no fault on status write");
  step_cause_a: assert property (STEP_EXC |-> $past(TRAP_FLAG) &&
    $past(EVT_READY) && $past(RETIRE_VALID) && $past(RETIRE_BRANCH) &&
    !$past(RETIRE_TASK_SWITCH)) else $error("step without plain branch");
  pair_order_a: assert property (pair_taken |=> pair_drained)
    else $error("branch and event not sent in two cycles");
  message_cause_a: assert property (BUS_TRACE_MESSAGE_VALID |-> !$past(EVT_READY) ||
    ($past(RETIRE_VALID) && $past(RETIRE_BRANCH)) || $past(EVT_VALID))
    else $error("message without cause");
  freeze_trigger_a: assert property ((|(GP_OVF & GP_PMI_EN)) || SAMPLE_BUF_THRESH
    |=> PERF_MONITOR_INTERRUPT) else $error("no interrupt after trigger");
  store_int_slot_a: assert property (STORE_INT |-> STORE_WR &&
    STORE_INDEX == bdc_pkg::STORE_THRESH) else $error("store interrupt off threshold slot");
endmodule : bdc_debug_trace_checker

////////////////////////////////////////////////////////////////////////////////
bind bdc_debug_trace bdc_debug_trace_checker u_checker (
  .CLK(CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RVALID(REG_RVALID), .REG_FAULT(REG_FAULT), .PRIV_TRACE_CAPABLE(PRIV_TRACE_CAPABLE),
  .TRAP_FLAG(TRAP_FLAG), .RETIRE_VALID(RETIRE_VALID), .RETIRE_BRANCH(RETIRE_BRANCH),
  .RETIRE_TASK_SWITCH(RETIRE_TASK_SWITCH), .EVT_VALID(EVT_VALID), .EVT_READY(EVT_READY),
  .STEP_EXC(STEP_EXC), .BUS_TRACE_MESSAGE_VALID(BUS_TRACE_MESSAGE_VALID),
  .STORE_WR(STORE_WR), .STORE_INDEX(STORE_INDEX), .STORE_INT(STORE_INT), .GP_OVF(GP_OVF),
  .GP_PMI_EN(GP_PMI_EN), .SAMPLE_BUF_THRESH(SAMPLE_BUF_THRESH),
  .PERF_MONITOR_INTERRUPT(PERF_MONITOR_INTERRUPT)
);

// ### test/bdc_trace_monitor.sv
/*
  Bus trace monitor: keeps every branch trace message in arrival order.
  Assumes messages are single-cycle pulses timed by the core clock.
*/
module bdc_trace_monitor (
  input wire logic clk,
  input wire logic valid,
  input wire logic [127:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [127:0] msgs[$];

  // A monitor only listens, so it can never stall or reorder the trace flow.
  always @(posedge clk) begin
    if (valid === 1'b1) begin
      msgs.push_back(data);
    end
  end
endmodule : bdc_trace_monitor

// ### test/testbench.sv
/*
  Self-checking bench for the branch trace and debug control block.
  Assumes the package, design, checker and trace monitor are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CTL = bdc_pkg::DEBUG_CONTROL_ADDR;
  localparam logic [31:0] STA = bdc_pkg::PERF_GLOBAL_STATUS_ADDR;
  localparam logic [31:0] GEN = bdc_pkg::GLOBAL_COUNTER_ENABLE_ADDR;
  localparam logic [31:0] OVR = bdc_pkg::PERF_OVERFLOW_RESET_ADDR;
  localparam logic [63:0] EN = 64'h0000_0007_0000_000f;

  logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, trap = 1'b0, dbg = 1'b0;
  logic rv = 1'b0, rb = 1'b0, rts = 1'b0, evv = 1'b0, sbt = 1'b0, srs = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [63:0] wdata = 64'h0, bf = 64'h0, bt = 64'h0, ef = 64'h0, et = 64'h0;
  logic [7:0] ver = 8'h04;
  logic [1:0] priv = 2'h0;
  logic [3:0] gov = 4'h0, gen = 4'h0, g;
  logic [2:0] fov = 3'h0;
  logic [11:0] fctl = 12'h0;
  logic [63:0] rdata, cen, d, st;
  logic rvalid, fault, cap, ready, step, mv, hw, sw, sint, perf_monitor_interrupt;
  logic [127:0] md, hd, sd;
  logic [bdc_pkg::STORE_IDX_W-1:0] sidx;
  int errors = 0, n_checks = 0, cyc = 0, n;

  bdc_debug_trace DUT (
    .CLK(clk), .RESET(reset), .REG_ADDR(addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .REG_FAULT(fault),
    .PERF_MONITOR_VERSION(ver), .PRIV_TRACE_CAPABLE(cap), .TRAP_FLAG(trap),
    .PRIVILEGE_LEVEL(priv), .RETIRE_VALID(rv), .RETIRE_BRANCH(rb),
    .RETIRE_TASK_SWITCH(rts), .BRANCH_FROM(bf), .BRANCH_TO(bt), .EVT_VALID(evv),
    .EVT_FROM(ef), .EVT_TO(et), .EVT_READY(ready), .DEBUG_EXC_OTHER(dbg), .STEP_EXC(step),
    .BUS_TRACE_MESSAGE_VALID(mv), .BUS_TRACE_MESSAGE_DATA(md), .HIST_WR(hw),
    .HIST_DATA(hd), .STORE_WR(sw), .STORE_INDEX(sidx), .STORE_DATA(sd), .STORE_INT(sint),
    .STORE_RESTART(srs), .GP_OVF(gov), .GP_PMI_EN(gen), .FIX_OVF(fov), .FIX_CTRL(fctl),
    .SAMPLE_BUF_THRESH(sbt), .PERF_MONITOR_INTERRUPT(perf_monitor_interrupt), .COUNT_ENABLE(cen)
  );
  bdc_trace_monitor mon (.clk(clk), .valid(mv), .data(md));

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] ctl_exp(input logic [63:0] v, input logic [7:0] version);
    logic [63:0] m;
    m = bdc_pkg::DEBUG_CONTROL_BASE_MASK;
    if (version > 8'h01) begin
      m = m | bdc_pkg::DEBUG_CONTROL_FREEZE_MASK;
    end
    return v & m;
  endfunction : ctl_exp

  function automatic logic shown(input logic [63:0] c, input logic [1:0] p);
    return (p == 2'h0) ? !c[9] : !c[10];
  endfunction : shown

  function automatic logic [127:0] rec(input logic [63:0] f, input logic [63:0] t);
    return {t, f};
  endfunction : rec

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Each driving task lets an edge pass first, so no strobe falls and rises in one step.
  task automatic wr(input logic [31:0] a, input logic [63:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [63:0] e, input logic f, input string nm);
    @(negedge clk);
    addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(nm, e, rdata);
    chk(nm, f, fault);
    chk({nm, " valid"}, 1'b1, rvalid);
  endtask : rd

  task automatic ev(input logic b, input logic t, input logic e);
    @(negedge clk);
    rv = 1'b1;
    rb = b;
    rts = t;
    evv = e;
    bf = {$urandom, $urandom};
    bt = {$urandom, $urandom};
    ef = {$urandom, $urandom};
    et = {$urandom, $urandom};
    @(negedge clk);
    rv = 1'b0;
    rts = 1'b0;
    evv = 1'b0;
  endtask : ev

  task automatic trig(input logic [3:0] go, input logic [2:0] fo, input logic [11:0] fc,
                      input logic s, input logic e);
    @(negedge clk);
    gov = go;
    gen = go;
    fov = fo;
    fctl = fc;
    sbt = s;
    @(negedge clk);
    gov = 4'h0;
    fov = 3'h0;
    sbt = 1'b0;
    chk("interrupt", e, perf_monitor_interrupt);
  endtask : trig

  // The ceiling is several times the few hundred cycles the sequence needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h1b951c5e));
    repeat (3) @(negedge clk);
    reset = 1'b0;
    chk("capable", 1'b1, cap);
    rd(CTL, 64'h0, 1'b0, "control reset");
    rd(STA, 64'h0, 1'b0, "status reset");
    rd(OVR, 64'h0, 1'b0, "overflow reset read");
    rd(32'h0000_0123, 64'h0, 1'b1, "unmapped");
    wr(STA, ~64'h0);
    chk("status write fault", 1'b1, fault);
    for (int i = 0; i < 6; i++) begin
      ver = (i < 2) ? 8'h01 : ((i < 4) ? 8'h02 : 8'h04);
      d = {$urandom, $urandom};
      wr(CTL, d);
      rd(CTL, ctl_exp(d, ver), 1'b0, "control");
    end
    trap = 1'b1;
    wr(CTL, 64'h3);
    ev(1'b1, 1'b1, 1'b0);
    chk("step task switch", 1'b0, step);
    ev(1'b0, 1'b0, 1'b0);
    chk("step plain retire", 1'b0, step);
    ev(1'b1, 1'b0, 1'b0);
    chk("step branch", 1'b1, step);
    rd(CTL, 64'h0, 1'b0, "control after step");
    wr(CTL, 64'h3);
    dbg = 1'b1;
    @(negedge clk);
    dbg = 1'b0;
    rd(CTL, 64'h0, 1'b0, "control after debug");
    trap = 1'b0;
    for (int i = 0; i < 8; i++) begin
      d = 64'h41 | (64'(i % 4) << 9);
      priv = (i < 4) ? 2'h0 : 2'($urandom_range(3, 1));
      wr(CTL, d);
      ev(1'b1, 1'b0, 1'b0);
      chk("message", shown(d, priv), mv);
      chk("history", 1'b1, hw);
      chk("history data", rec(bf, bt), hd);
      if (mv === 1'b1) begin
        chk("message data", rec(bf, bt), md);
      end
    end
    priv = 2'h0;
    wr(CTL, 64'h40);
    n = mon.msgs.size();
    ev(1'b1, 1'b0, 1'b1);
    chk("ready", 1'b0, ready);
    repeat (2) @(negedge clk);
    chk("message count", n + 2, mon.msgs.size());
    chk("branch message", rec(bf, bt), mon.msgs[n]);
    chk("event message", rec(ef, et), mon.msgs[n + 1]);
    for (int i = 0; i < 2; i++) begin
      ver = (i == 1) ? 8'h04 : 8'h02;
      wr(CTL, 64'h1801);
      wr(GEN, EN);
      g = 4'h1 << $urandom_range(3, 0);
      trig(g, 3'h0, 12'h0, 1'b0, 1'b1);
      st = (i == 1) ? (64'(g) | 64'h0c00_0000_0000_0000) : 64'(g);
      rd(STA, st, 1'b0, "status");
      rd(CTL, (i == 1) ? 64'h1801 : 64'h1800, 1'b0, "control frozen");
      rd(GEN, (i == 1) ? EN : 64'h0, 1'b0, "enable frozen");
      chk("counts stopped", 64'h0, cen);
      wr(OVR, (i == 1) ? st : ~64'h0);
      rd(STA, 64'h0, 1'b0, "status acked");
      chk("counts resumed", (i == 1) ? EN : 64'h0, cen);
    end
    trig(4'h0, 3'h4, 12'h800, 1'b0, 1'b1);
    trig(4'h0, 3'h4, 12'h400, 1'b0, 1'b0);
    trig(4'h0, 3'h0, 12'h0, 1'b1, 1'b1);
    // The first pass wraps the buffer; the second stops it full in interrupt mode.
    for (int m = 0; m < 2; m++) begin
      wr(CTL, (m == 1) ? 64'h180 : 64'h80);
      for (int i = 0; i < 64; i++) begin
        ev(1'b1, 1'b0, 1'b0);
        chk("store write", 1'b1, sw);
        chk("store slot", i, sidx);
        chk("store data", rec(bf, bt), sd);
        chk("store interrupt", m == 1 && i == 60, sint);
      end
    end
    ev(1'b1, 1'b0, 1'b0);
    chk("store full", 1'b0, sw);
    srs = 1'b1;
    @(negedge clk);
    srs = 1'b0;
    ev(1'b1, 1'b0, 1'b0);
    chk("store restart", 1'b1, sw);
    chk("store restart slot", 6'h00, sidx);
    tally_and_finish();
  end
endmodule : testbench

// ### verilog/bdc_debug_trace.sv
/*
  Branch stepping, trace message, history capture, trace store and freeze-on-interrupt control.
  Only one record leaves per cycle, so a branch that meets an interrupt holds EVT_READY low
  for one cycle.
  Assumes the core presents retire and interrupt events only while EVT_READY is high and that
  the history stack, store memory and counters live outside; everything runs on CLK.
*/
module bdc_debug_trace (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [31:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [63:0] REG_WDATA,
  output logic [63:0] REG_RDATA,
  output logic REG_RVALID,
  output logic REG_FAULT,
  input wire logic [7:0] PERF_MONITOR_VERSION,
  output logic PRIV_TRACE_CAPABLE,
  input wire logic TRAP_FLAG,
  input wire logic [1:0] PRIVILEGE_LEVEL,
  input wire logic RETIRE_VALID,
  input wire logic RETIRE_BRANCH,
  input wire logic RETIRE_TASK_SWITCH,
  input wire logic [63:0] BRANCH_FROM,
  input wire logic [63:0] BRANCH_TO,
  input wire logic EVT_VALID,
  input wire logic [63:0] EVT_FROM,
  input wire logic [63:0] EVT_TO,
  output logic EVT_READY,
  input wire logic DEBUG_EXC_OTHER,
  output logic STEP_EXC,
  output logic BUS_TRACE_MESSAGE_VALID,
  output logic [127:0] BUS_TRACE_MESSAGE_DATA,
  output logic HIST_WR,
  output logic [127:0] HIST_DATA,
  output logic STORE_WR,
  output logic [bdc_pkg::STORE_IDX_W-1:0] STORE_INDEX,
  output logic [127:0] STORE_DATA,
  output logic STORE_INT,
  input wire logic STORE_RESTART,
  input wire logic [bdc_pkg::NUM_GP-1:0] GP_OVF,
  input wire logic [bdc_pkg::NUM_GP-1:0] GP_PMI_EN,
  input wire logic [bdc_pkg::NUM_FIX-1:0] FIX_OVF,
  input wire logic [bdc_pkg::NUM_FIX*bdc_pkg::FIX_FIELD_W-1:0] FIX_CTRL,
  input wire logic SAMPLE_BUF_THRESH,
  output logic PERF_MONITOR_INTERRUPT,
  output logic [63:0] COUNT_ENABLE
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  // All state lives in one struct so the register stage is a single assignment.
  typedef struct packed {
    logic [63:0] dbgctl;
    logic [63:0] gstat;
    logic [63:0] gen;
    logic [63:0] rdata;
    logic rvalid;
    logic fault;
    logic step_exc;
    logic perf_monitor_interrupt;
    logic msg_valid;
    logic [127:0] msg_data;
    logic pend;
    logic pend_allow;
    logic [127:0] pend_data;
    logic hist_wr;
    logic [127:0] hist_data;
    logic st_wr;
    logic [bdc_pkg::STORE_IDX_W-1:0] st_idx;
    logic [bdc_pkg::STORE_IDX_W-1:0] st_wr_idx;
    logic [127:0] st_data;
    logic st_full;
    logic st_int;
  } bdc_state_t;

  bdc_state_t s_q;
  bdc_state_t s_d;

  logic [63:0] status_set;
  logic freeze_trigger;
  logic store_thresh_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers.
  // A record carries the target in its upper half and the source in its lower half.
  function automatic logic [127:0] record_of(input logic [63:0] from, input logic [63:0] to);
    return {to, from};
  endfunction : record_of

  // The status register is readable, so only a read of an unlisted number is refused.
  function automatic logic read_refused(input logic [31:0] addr);
    return !(addr inside {bdc_pkg::DEBUG_CONTROL_ADDR, bdc_pkg::PERF_GLOBAL_STATUS_ADDR,
                          bdc_pkg::GLOBAL_COUNTER_ENABLE_ADDR,
                          bdc_pkg::PERF_OVERFLOW_RESET_ADDR});
  endfunction : read_refused

  function automatic logic [63:0] read_value(input logic [31:0] addr, input bdc_state_t s);
    logic [63:0] v;
    case (addr)
      bdc_pkg::DEBUG_CONTROL_ADDR: v = s.dbgctl;
      bdc_pkg::PERF_GLOBAL_STATUS_ADDR: v = s.gstat;
      bdc_pkg::GLOBAL_COUNTER_ENABLE_ADDR: v = s.gen;
      // The overflow reset register is write-only and reads as zero, as do refused numbers.
      default: v = 64'h0;
    endcase
    return v;
  endfunction : read_value

  ////////////////////////////////////////////////////////////////////////////////
  // Event and record selection.
  logic take_branch;
  logic take_evt;
  logic pair_hit;
  logic rec_valid;
  logic rec_allow;
  logic [127:0] rec_data;
  logic step_hit;
  logic debug_exc;
  logic streamlined;
  logic freeze_ok;
  logic hist_on;
  logic store_on;

  always_comb begin
    take_branch = RETIRE_VALID && RETIRE_BRANCH && !s_q.pend;
    take_evt = EVT_VALID && !s_q.pend;
    // A branch and an interrupt in one cycle need two records, so one waits a cycle.
    pair_hit = take_branch && take_evt;
    streamlined = bdc_pkg::is_streamlined(PERF_MONITOR_VERSION);
    freeze_ok = bdc_pkg::freeze_supported(PERF_MONITOR_VERSION);
    // Task switches are filtered out so a switch never lands in the stepping handler.
    step_hit = s_q.dbgctl[bdc_pkg::BRANCH_STEP_BIT] && TRAP_FLAG && take_branch &&
               !RETIRE_TASK_SWITCH;
    debug_exc = step_hit || DEBUG_EXC_OTHER;
    // A held second record goes out before any new event is accepted.
    if (s_q.pend) begin
      rec_valid = 1'b1;
      rec_allow = s_q.pend_allow;
      rec_data = s_q.pend_data;
    end else begin
      rec_valid = take_branch || take_evt;
      rec_allow = bdc_pkg::trace_allowed(s_q.dbgctl, PRIVILEGE_LEVEL);
      rec_data = take_branch ? record_of(BRANCH_FROM, BRANCH_TO) : record_of(EVT_FROM, EVT_TO);
    end
    hist_on = s_q.dbgctl[bdc_pkg::HIST_RECORD_BIT] && !s_q.gstat[bdc_pkg::STAT_HIST_FROZEN_BIT];
    store_on = s_q.dbgctl[bdc_pkg::TRACE_STORE_BIT] && !s_q.st_full;
    store_thresh_hit = store_on && rec_valid && rec_allow &&
                       s_q.dbgctl[bdc_pkg::STORE_INT_EN_BIT] &&
                       s_q.st_idx == bdc_pkg::STORE_THRESH;
  end

  assign EVT_READY = !s_q.pend;

  bdc_freeze_detect u_freeze_detect (
    .gp_ovf(GP_OVF),
    .gp_pmi_en(GP_PMI_EN),
    .fix_ovf(FIX_OVF),
    .fix_ctrl(FIX_CTRL),
    .sample_thresh(SAMPLE_BUF_THRESH),
    .store_thresh(store_thresh_hit),
    .status_set(status_set),
    .trigger(freeze_trigger)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  // Later blocks override earlier ones, which sets the priority: software, then hardware.
  always_comb begin
    logic [63:0] wmask;
    wmask = bdc_pkg::DEBUG_CONTROL_BASE_MASK;
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.fault = 1'b0;
    s_d.step_exc = step_hit;
    s_d.perf_monitor_interrupt = freeze_trigger;
    s_d.msg_valid = 1'b0;
    s_d.hist_wr = 1'b0;
    s_d.st_wr = 1'b0;
    s_d.st_int = 1'b0;

    // Freeze controls exist only on version two or later.
    if (freeze_ok) begin
      wmask = wmask | bdc_pkg::DEBUG_CONTROL_FREEZE_MASK;
    end

    // Register reads return data one cycle later; unmapped numbers fault.
    if (REG_RD) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = read_value(REG_ADDR, s_q);
      s_d.fault = read_refused(REG_ADDR);
    end

    // Register writes; the status register is read-only.
    if (REG_WR) begin
      case (REG_ADDR)
        bdc_pkg::DEBUG_CONTROL_ADDR: s_d.dbgctl = REG_WDATA & wmask;
        bdc_pkg::GLOBAL_COUNTER_ENABLE_ADDR: s_d.gen = REG_WDATA;
        bdc_pkg::PERF_OVERFLOW_RESET_ADDR: s_d.gstat = s_q.gstat & ~REG_WDATA;
        default: s_d.fault = 1'b1;
      endcase
    end

    // New status indications win over an acknowledge in the same cycle.
    s_d.gstat = s_d.gstat | status_set;

    // Freeze handling follows the software write so hardware has the last word.
    if (freeze_trigger && freeze_ok) begin
      if (s_q.dbgctl[bdc_pkg::HIST_FREEZE_EN_BIT]) begin
        if (streamlined) begin
          s_d.gstat[bdc_pkg::STAT_HIST_FROZEN_BIT] = 1'b1;
        end else begin
          s_d.dbgctl[bdc_pkg::HIST_RECORD_BIT] = 1'b0;
        end
      end
      if (s_q.dbgctl[bdc_pkg::CTR_FREEZE_EN_BIT]) begin
        if (streamlined) begin
          s_d.gstat[bdc_pkg::STAT_CTR_FROZEN_BIT] = 1'b1;
        end else begin
          s_d.gen = 64'h0;
        end
      end
    end

    // A debug exception disarms stepping and history capture; stored entries stay.
    if (debug_exc) begin
      s_d.dbgctl[bdc_pkg::BRANCH_STEP_BIT] = 1'b0;
      s_d.dbgctl[bdc_pkg::HIST_RECORD_BIT] = 1'b0;
    end

    // Coincident branch and interrupt: branch record now, interrupt record next cycle.
    s_d.pend = pair_hit;
    if (pair_hit) begin
      s_d.pend_data = record_of(EVT_FROM, EVT_TO);
      s_d.pend_allow = bdc_pkg::trace_allowed(s_q.dbgctl, PRIVILEGE_LEVEL);
    end

    // History, bus message and store act on the same record side by side.
    if (rec_valid) begin
      // History keeps recording while messages flow; older variants forbid the pair, so
      // software owns that rule and the history contents are then its own concern.
      if (hist_on) begin
        s_d.hist_wr = 1'b1;
        s_d.hist_data = rec_data;
      end
      if (s_q.dbgctl[bdc_pkg::TRACE_MESSAGE_BIT] && rec_allow) begin
        s_d.msg_valid = 1'b1;
        s_d.msg_data = rec_data;
      end
      if (store_on && rec_allow) begin
        s_d.st_wr = 1'b1;
        s_d.st_wr_idx = s_q.st_idx;
        s_d.st_data = rec_data;
        if (s_q.st_idx == bdc_pkg::STORE_LAST) begin
          s_d.st_idx = '0;
          // Interrupt mode holds the buffer once full so no record is overwritten.
          s_d.st_full = s_q.dbgctl[bdc_pkg::STORE_INT_EN_BIT];
        end else begin
          s_d.st_idx = s_q.st_idx + 1'b1;
        end
        if (store_thresh_hit) begin
          s_d.st_int = 1'b1;
        end
      end
    end

    // A restart overrides a record that fills the buffer in the same cycle.
    if (STORE_RESTART) begin
      s_d.st_idx = '0;
      s_d.st_full = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_q <= '0;
      s_q.dbgctl <= bdc_pkg::DEBUG_CONTROL_RESET;
      s_q.gstat <= bdc_pkg::GLOBAL_STATUS_RESET;
      s_q.gen <= bdc_pkg::GLOBAL_ENABLE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  // Most outputs come straight from a flip-flop; EVT_READY and COUNT_ENABLE are combinational and PRIV_TRACE_CAPABLE is tied high.
  assign REG_RDATA = s_q.rdata;
  assign REG_RVALID = s_q.rvalid;
  assign REG_FAULT = s_q.fault;
  assign PRIV_TRACE_CAPABLE = 1'b1;
  assign STEP_EXC = s_q.step_exc;
  assign BUS_TRACE_MESSAGE_VALID = s_q.msg_valid;
  assign BUS_TRACE_MESSAGE_DATA = s_q.msg_data;
  assign HIST_WR = s_q.hist_wr;
  assign HIST_DATA = s_q.hist_data;
  assign STORE_WR = s_q.st_wr;
  assign STORE_INDEX = s_q.st_wr_idx;
  assign STORE_DATA = s_q.st_data;
  assign STORE_INT = s_q.st_int;
  assign PERF_MONITOR_INTERRUPT = s_q.perf_monitor_interrupt;
  // Streamlined counter freeze gates counting without touching the enable register.
  assign COUNT_ENABLE = s_q.gstat[bdc_pkg::STAT_CTR_FROZEN_BIT] ? 64'h0 : s_q.gen;

endmodule : bdc_debug_trace

// ### verilog/bdc_freeze_detect.sv
/*
  Combinational overflow and freeze-trigger decode for the performance status.
  Assumes overflow and threshold inputs are single-cycle events from the counters and buffers.
*/
module bdc_freeze_detect (
  input wire logic [bdc_pkg::NUM_GP-1:0] gp_ovf,
  input wire logic [bdc_pkg::NUM_GP-1:0] gp_pmi_en,
  input wire logic [bdc_pkg::NUM_FIX-1:0] fix_ovf,
  input wire logic [bdc_pkg::NUM_FIX*bdc_pkg::FIX_FIELD_W-1:0] fix_ctrl,
  input wire logic sample_thresh,
  input wire logic store_thresh,
  output logic [63:0] status_set,
  output logic trigger
);

  ////////////////////////////////////////////////////////////////////////////////
  // Every overflow is logged in status; only interrupt-enabled ones fire a freeze.
  always_comb begin
    status_set = 64'h0;
    trigger = sample_thresh || store_thresh;
    for (int i = 0; i < bdc_pkg::NUM_GP; i++) begin
      status_set[bdc_pkg::STAT_GP_LSB + i] = gp_ovf[i];
      if (gp_ovf[i] && gp_pmi_en[i]) begin
        trigger = 1'b1;
      end
    end
    for (int j = 0; j < bdc_pkg::NUM_FIX; j++) begin
      status_set[bdc_pkg::STAT_FIX_LSB + j] = fix_ovf[j];
      if (fix_ovf[j] && fix_ctrl[j*bdc_pkg::FIX_FIELD_W + bdc_pkg::FIX_PMI_BIT]) begin
        trigger = 1'b1;
      end
    end
    status_set[bdc_pkg::STAT_SAMPLE_BUF_BIT] = sample_thresh;
    status_set[bdc_pkg::STAT_STORE_BUF_BIT] = store_thresh;
  end

endmodule : bdc_freeze_detect

// ### verilog/bdc_pkg.sv
/*
  Constants, register map and shared helpers for the branch trace and debug control block.
  Assumes a single core clock and a register port addressed by the documented register numbers.
*/
package bdc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register numbers.
  localparam logic [31:0] DEBUG_CONTROL_ADDR = 32'h0000_01d9;
  localparam logic [31:0] PERF_GLOBAL_STATUS_ADDR = 32'h0000_038e;
  localparam logic [31:0] GLOBAL_COUNTER_ENABLE_ADDR = 32'h0000_038f;
  localparam logic [31:0] PERF_OVERFLOW_RESET_ADDR = 32'h0000_0390;

  ////////////////////////////////////////////////////////////////////////////////
  // Debug control register fields.
  localparam int HIST_RECORD_BIT = 0;
  localparam int BRANCH_STEP_BIT = 1;
  localparam int TRACE_MESSAGE_BIT = 6;
  localparam int TRACE_STORE_BIT = 7;
  localparam int STORE_INT_EN_BIT = 8;
  localparam int PRIV_SUPPRESS_BIT = 9;
  localparam int USER_SUPPRESS_BIT = 10;
  localparam int HIST_FREEZE_EN_BIT = 11;
  localparam int CTR_FREEZE_EN_BIT = 12;
  localparam logic [63:0] DEBUG_CONTROL_RESET = 64'h0;
  localparam logic [63:0] DEBUG_CONTROL_BASE_MASK = 64'h0000_0000_0000_07c3;
  localparam logic [63:0] DEBUG_CONTROL_FREEZE_MASK = 64'h0000_0000_0000_1800;

  ////////////////////////////////////////////////////////////////////////////////
  // Global status fields and other reset values.
  localparam int NUM_GP = 4;
  localparam int NUM_FIX = 3;
  localparam int FIX_FIELD_W = 4;
  localparam int FIX_PMI_BIT = 3;
  localparam int STAT_GP_LSB = 0;
  localparam int STAT_FIX_LSB = 32;
  localparam int STAT_HIST_FROZEN_BIT = 58;
  localparam int STAT_CTR_FROZEN_BIT = 59;
  localparam int STAT_STORE_BUF_BIT = 61;
  localparam int STAT_SAMPLE_BUF_BIT = 62;
  localparam logic [63:0] GLOBAL_STATUS_RESET = 64'h0;
  localparam logic [63:0] GLOBAL_ENABLE_RESET = 64'h0;
  localparam logic [7:0] LEGACY_MAX_VERSION = 8'h03;
  localparam logic [7:0] FREEZE_MIN_VERSION = 8'h02;

  ////////////////////////////////////////////////////////////////////////////////
  // Trace store buffer geometry.
  localparam int STORE_IDX_W = 6;
  localparam logic [STORE_IDX_W-1:0] STORE_LAST = 6'h3f;
  localparam logic [STORE_IDX_W-1:0] STORE_THRESH = 6'h3c;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic trace_allowed(input logic [63:0] ctl, input logic [1:0] priv);
    logic blocked;
    blocked = (ctl[PRIV_SUPPRESS_BIT] && priv == 2'h0) ||
              (ctl[USER_SUPPRESS_BIT] && priv != 2'h0);
    return !blocked;
  endfunction : trace_allowed

  function automatic logic is_streamlined(input logic [7:0] ver);
    return ver > LEGACY_MAX_VERSION;
  endfunction : is_streamlined

  function automatic logic freeze_supported(input logic [7:0] ver);
    return ver >= FREEZE_MIN_VERSION;
  endfunction : freeze_supported

endpackage : bdc_pkg
